// >>> common/sfcmd_pkg.sv
// Constants and carrier types for the serial flash command interpreter.
// Assumes mclk well above the serial clock so every link edge is seen.
package sfcmd_pkg;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_ID_READ_A = 8'h90;
	localparam logic [7:0] OP_ID_READ_B = 8'hAB;
	// Defaults for the opcodes that can be configured
	localparam logic [7:0] OP_STATUS_READ_DEF = 8'h05;
	localparam logic [7:0] OP_WRITE_ENABLE_DEF = 8'h06;
	localparam logic [7:0] OP_STATUS_ARM_DEF = 8'h50;
	localparam logic [7:0] OP_STATUS_WRITE_DEF = 8'h01;
	// Identity bytes: arbitrary neutral values
	localparam logic [7:0] MAKER_CODE_DEF = 8'h5A;
	localparam logic [7:0] PART_CODE_DEF = 8'hA5;
	// Status register bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam int ST_BP_LO = 2;
	localparam int ST_BP_HI = 3;
	localparam int ST_AAI = 6;
	localparam int ST_LOCK = 7;
	localparam logic [7:0] STATUS_RESET = 8'h1C;
	localparam int OPCODE_BITS = 8;
	localparam int ADDR_BITS = 24;
	localparam int SYNC_STAGES = 2;

	typedef struct packed {
		logic sel_n;
		logic sck;
		logic sdi;
		logic wp_n;
	} sfcmd_pins_t;

	typedef struct packed {
		logic data;
		logic oe_n;
	} sfcmd_sdo_t;
endpackage

// >>> hw/sfcmd_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes inputs are asynchronous to mclk.
`timescale 1ns/100ps
module sfcmd_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	initial
	begin
		if (WIDTH < 1)
			$error("sfcmd_sync: WIDTH must be positive");
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			meta_q <= WIDTH'(4'b1001);
			sync_out <= WIDTH'(4'b1001);
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// >>> hw/sfcmd_core.sv
// Serial flash status-register, write-protect and identification command interpreter.
// Assumes mclk at least eight times the serial clock; pins arrive asynchronously.
`timescale 1ns/100ps
module sfcmd_core #(
	parameter logic [7:0] OP_STATUS_READ = sfcmd_pkg::OP_STATUS_READ_DEF,
	parameter logic [7:0] OP_WRITE_ENABLE = sfcmd_pkg::OP_WRITE_ENABLE_DEF,
	parameter logic [7:0] OP_STATUS_ARM = sfcmd_pkg::OP_STATUS_ARM_DEF,
	parameter logic [7:0] OP_STATUS_WRITE = sfcmd_pkg::OP_STATUS_WRITE_DEF,
	parameter logic [7:0] MAKER_CODE = sfcmd_pkg::MAKER_CODE_DEF,
	parameter logic [7:0] PART_CODE = sfcmd_pkg::PART_CODE_DEF
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Serial pins
	input wire sfcmd_pkg::sfcmd_pins_t pins,
	output sfcmd_pkg::sfcmd_sdo_t sdo,
	// Array engine hooks
	input wire logic busy_in,
	input wire logic aai_set,
	// Status view
	output logic [7:0] status
);
	typedef enum logic [4:0] {
		SFCMD_OPCODE = 5'b00001,
		SFCMD_STATUS_OUT = 5'b00010,
		SFCMD_ADDR = 5'b00100,
		SFCMD_ID_OUT = 5'b01000,
		SFCMD_DATA_IN = 5'b10000
	} sfcmd_state_t;

	function automatic logic is_id_op(input logic [7:0] op);
		is_id_op = (op == sfcmd_pkg::OP_ID_READ_A) || (op == sfcmd_pkg::OP_ID_READ_B);
	endfunction

	initial
	begin
		if (OP_STATUS_READ == OP_WRITE_ENABLE || OP_STATUS_ARM == OP_STATUS_WRITE)
			$error("sfcmd_core: configurable opcodes must differ");
	end

	sfcmd_pkg::sfcmd_pins_t pin_s;
	logic sck_q, sel_n_q;
	logic sck_rise, sck_fall, sel_rise, sel_fall;
	sfcmd_state_t state_q;
	logic [4:0] cnt_q;
	logic [7:0] shin_q, op_q, data_q, shout_q;
	logic armed_q, id_sel_q;
	logic [2:0] out_cnt_q;
	logic wel_q, aai_q, bp_lo_q, bp_hi_q, lock_q;
	logic oe_n_q, sdo_q;
	logic [7:0] shin_next;

	sfcmd_sync #(.WIDTH(4)) u_sync (
		.mclk(mclk),
		.srst(srst),
		.async_in(pins),
		.sync_out(pin_s)
	);

	// Edge detection on synchronised levels
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			sck_q <= 1'b0;
			sel_n_q <= 1'b1;
		end
		else
		begin
			sck_q <= pin_s.sck;
			sel_n_q <= pin_s.sel_n;
		end
	end

	assign sck_rise = !pin_s.sel_n && pin_s.sck && !sck_q;
	assign sck_fall = !pin_s.sel_n && !pin_s.sck && sck_q;
	assign sel_rise = pin_s.sel_n && !sel_n_q;
	assign sel_fall = !pin_s.sel_n && sel_n_q;
	assign shin_next = {shin_q[6:0], pin_s.sdi};

	// Frame decoder
	always_ff @(posedge mclk)
	begin
		if (srst || sel_fall)
		begin
			state_q <= SFCMD_OPCODE;
			cnt_q <= 5'd0;
			shin_q <= 8'h00;
			op_q <= 8'h00;
			data_q <= 8'h00;
		end
		else if (sck_rise)
		begin
			shin_q <= shin_next;
			cnt_q <= cnt_q + 5'd1;
			unique case (state_q)
				SFCMD_OPCODE:
				begin
					if (cnt_q == 5'(sfcmd_pkg::OPCODE_BITS - 1))
					begin
						op_q <= shin_next;
						cnt_q <= 5'd0;
						if (shin_next == OP_STATUS_READ)
							state_q <= SFCMD_STATUS_OUT;
						else if (is_id_op(shin_next))
							state_q <= SFCMD_ADDR;
						else if (shin_next == OP_STATUS_WRITE)
							state_q <= SFCMD_DATA_IN;
					end
				end
				SFCMD_ADDR:
				begin
					if (cnt_q == 5'(sfcmd_pkg::ADDR_BITS - 1))
						state_q <= SFCMD_ID_OUT;
				end
				SFCMD_DATA_IN:
				begin
					if (cnt_q == 5'(sfcmd_pkg::OPCODE_BITS - 1))
						data_q <= shin_next;
				end
				SFCMD_STATUS_OUT, SFCMD_ID_OUT:
				begin
					cnt_q <= 5'd0;
				end
			endcase
		end
	end

	assign status = {lock_q, aai_q, 2'b00, bp_hi_q, bp_lo_q, wel_q, busy_in};

	// Output shifter: loads on first fall after the last input bit, MSB first
	always_ff @(posedge mclk)
	begin
		if (srst || pin_s.sel_n)
		begin
			oe_n_q <= 1'b1;
			sdo_q <= 1'b0;
			shout_q <= 8'h00;
			out_cnt_q <= 3'd0;
		end
		else if (sck_fall && (state_q == SFCMD_STATUS_OUT || state_q == SFCMD_ID_OUT))
		begin
			oe_n_q <= 1'b0;
			if (out_cnt_q == 3'd0)
			begin
				if (state_q == SFCMD_STATUS_OUT)
				begin
					sdo_q <= status[7];
					shout_q <= {status[6:0], 1'b0};
				end
				else
				begin
					sdo_q <= id_sel_q ? PART_CODE[7] : MAKER_CODE[7];
					shout_q <= id_sel_q ? {PART_CODE[6:0], 1'b0} : {MAKER_CODE[6:0], 1'b0};
				end
			end
			else
			begin
				sdo_q <= shout_q[7];
				shout_q <= {shout_q[6:0], 1'b0};
			end
			out_cnt_q <= out_cnt_q + 3'd1;
		end
	end

	// Identity select: loaded from the address LSB, then alternated at each byte end
	always_ff @(posedge mclk)
	begin
		if (srst || pin_s.sel_n)
			id_sel_q <= 1'b0;
		else if (sck_rise && state_q == SFCMD_ADDR)
			id_sel_q <= pin_s.sdi;
		else if (sck_fall && out_cnt_q == 3'd7)
			id_sel_q <= !id_sel_q;
	end

	assign sdo.data = sdo_q;
	assign sdo.oe_n = oe_n_q;

	// Status bits committed at the frame-ending select rise; AAI is also set by the engine in any cycle
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			armed_q <= 1'b0;
			wel_q <= sfcmd_pkg::STATUS_RESET[sfcmd_pkg::ST_WEL];
			aai_q <= sfcmd_pkg::STATUS_RESET[sfcmd_pkg::ST_AAI];
			bp_lo_q <= sfcmd_pkg::STATUS_RESET[sfcmd_pkg::ST_BP_LO];
			bp_hi_q <= sfcmd_pkg::STATUS_RESET[sfcmd_pkg::ST_BP_HI];
			lock_q <= sfcmd_pkg::STATUS_RESET[sfcmd_pkg::ST_LOCK];
		end
		else
		begin
			if (sel_rise && state_q == SFCMD_OPCODE && cnt_q == 5'd0)
			begin
				// Whole opcode seen, no trailing bits
				armed_q <= (op_q == OP_STATUS_ARM);
				if (op_q == OP_WRITE_ENABLE)
					wel_q <= 1'b1;
				if (op_q == sfcmd_pkg::OP_WRITE_DISABLE)
				begin
					wel_q <= 1'b0;
					aai_q <= 1'b0;
				end
			end
			else if (sel_rise && state_q == SFCMD_DATA_IN && cnt_q == 5'd8)
			begin
				armed_q <= 1'b0;
				// Lock and pin judged as they stand now
				if (armed_q && !(!pin_s.wp_n && lock_q))
				begin
					bp_lo_q <= data_q[sfcmd_pkg::ST_BP_LO];
					bp_hi_q <= data_q[sfcmd_pkg::ST_BP_HI];
					lock_q <= data_q[sfcmd_pkg::ST_LOCK];
				end
			end
			else if (sel_rise)
				armed_q <= 1'b0;
			// Engine set wins over a write disable in the same cycle
			if (aai_set)
				aai_q <= 1'b1;
		end
	end
endmodule

// >>> verification/sfcmd_core_sva.sv
// Port checker for sfcmd_core.
// Assumes pins reach mclk through a two-flop synchroniser.
`timescale 1ns/100ps
module sfcmd_core_sva (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Watched ports
	input wire sfcmd_pkg::sfcmd_pins_t pins,
	input wire sfcmd_pkg::sfcmd_sdo_t sdo,
	input wire logic busy_in,
	input wire logic aai_set,
	input wire logic [7:0] status
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	busy_view_a: assert property (status[0] == busy_in)
		else $error("busy view");
	oe_idle_a: assert property (pins.sel_n [*4] |-> sdo.oe_n)
		else $error("output on while idle");
	oe_open_a: assert property ($fell(sdo.oe_n) |-> !$past(pins.sck, 3))
		else $error("output opened off a fall");
	shift_fall_a: assert property (!sdo.oe_n && $changed(sdo.data) |-> !$past(pins.sck, 3))
		else $error("data moved off a fall");
	resv_zero_a: assert property (status[5:4] == 2'b00)
		else $error("reserved bits set");
	frame_hold_a: assert property (!pins.sel_n [*8] |-> $stable({status[7], status[3:1]}))
		else $error("status moved in frame");
	wel_rise_a: assert property ($rose(status[1]) |-> $past(pins.sel_n, 2))
		else $error("latch set in frame");
	lock_hold_a: assert property ((status[7] && !pins.wp_n) [*8] |=>
		$stable({status[7], status[3:2]})) else $error("locked status moved");
	cover property ($rose(status[7]));
	cover property ($fell(sdo.oe_n));
	cover property (aai_set ##[1:4] status[6]);
endmodule

bind sfcmd_core sfcmd_core_sva u_sva (.mclk(mclk), .srst(srst), .pins(pins), .sdo(sdo),
	.busy_in(busy_in), .aai_set(aai_set), .status(status));

// >>> verification/sfcmd_host_model.sv
// SPI host model, mode 0, serial clock of 160 ns.
// Assumes mclk of 4 ns; pins change on falling mclk edges.
`timescale 1ns/100ps
module sfcmd_host_model (
	// Clock
	input wire logic mclk,
	// Link
	output sfcmd_pkg::sfcmd_pins_t pins,
	input wire sfcmd_pkg::sfcmd_sdo_t sdo,
	input wire logic wp_n
);
	initial pins = 4'b1001;
	always @(negedge mclk) pins.wp_n = wp_n;
	// One frame; clock stands low outside it
	task automatic xfer(input logic [7:0] op, input logic [31:0] tx, input int ntx,
		input int nrx, output logic [23:0] rx);
		logic [39:0] sh;
		sh = {op, tx << (32 - ntx)};
		rx = '0;
		pins.sel_n = 1'b0;
		for (int k = 0; k < 8 + ntx + nrx; k++)
		begin
			pins.sdi = sh[39];
			sh = sh << 1;
			repeat (20) @(negedge mclk);
			pins.sck = 1'b1;
			if (k >= 8 + ntx)
				rx = {rx[22:0], sdo.data};
			repeat (20) @(negedge mclk);
			pins.sck = 1'b0;
		end
		repeat (20) @(negedge mclk);
		pins.sel_n = 1'b1;
		pins.sdi = ~pins.sdi;
		repeat (40) @(negedge mclk);
	endtask
endmodule

// >>> verification/sfcmd_core_tb_top.sv
// Self-checking bench for sfcmd_core.
// Assumes the host model drives every serial pin.
`timescale 1ns/100ps
`define CMP(g, x) begin n_compared++; if ((g) !== (x)) begin n_fail++; \
	$display("unexpected at %0t got %h exp %h", $time, g, x); end end
module sfcmd_core_tb_top;
	localparam logic [7:0] RD = sfcmd_pkg::OP_STATUS_READ_DEF;
	localparam logic [7:0] WE = sfcmd_pkg::OP_WRITE_ENABLE_DEF;
	localparam logic [7:0] M = sfcmd_pkg::MAKER_CODE_DEF;
	localparam logic [7:0] P = sfcmd_pkg::PART_CODE_DEF;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic busy_in = 1'b0;
	logic aai_set = 1'b0;
	logic wp_n = 1'b1;
	sfcmd_pkg::sfcmd_pins_t pins;
	sfcmd_pkg::sfcmd_sdo_t sdo;
	logic [7:0] status;
	logic [7:0] st = sfcmd_pkg::STATUS_RESET & 8'hCF;
	logic [7:0] d;
	logic [23:0] got;
	logic [23:0] e;
	logic [23:0] exp_v;
	logic [23:0] junk;
	logic [23:0] exp_q[$];
	logic [7:0] dtab[5] = '{8'h00, 8'h84, 8'h08, 8'h00, 8'h8C};
	logic [4:0] wtab = 5'b01001;
	int n_fail = 0;
	int n_compared = 0;
	int cyc = 0;
	event seen;
	always #2 mclk = ~mclk;
	sfcmd_core DUT (.mclk(mclk), .srst(srst), .pins(pins), .sdo(sdo), .busy_in(busy_in),
		.aai_set(aai_set), .status(status));
	sfcmd_host_model host (.mclk(mclk), .pins(pins), .sdo(sdo), .wp_n(wp_n));
	task automatic note(input logic [23:0] v, input logic [23:0] x);
		exp_q.push_back(x);
		got = v;
		-> seen;
		@(negedge mclk);
	endtask
	task automatic run(input logic [7:0] op, input logic [31:0] tx, input int ntx,
		input int nrx, input logic [23:0] x);
		logic [23:0] r;
		host.xfer(op, tx, ntx, nrx, r);
		note(r, x);
	endtask
	task automatic cmd(input logic [7:0] op, input logic [31:0] tx, input int ntx);
		host.xfer(op, tx, ntx, 0, junk);
	endtask
	task automatic finish_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(seen)
	begin
		exp_v = exp_q.pop_front();
		`CMP(got, exp_v)
	end
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_fail++;
			finish_test();
		end
	end
	initial
	begin
		void'($urandom(39));
		repeat (6) @(negedge mclk);
		srst = 1'b0;
		repeat (4) @(negedge mclk);
		note({16'h0000, status}, {16'h0000, st});
		$display("test reset done");
		busy_in = 1'b1;
		cmd(WE, 0, 0);
		run(RD, 0, 0, 16, {8'h00, st | 8'h03, st | 8'h03});
		busy_in = 1'b0;
		aai_set = 1'b1;
		@(negedge mclk);
		aai_set = 1'b0;
		note({16'h0000, status}, {16'h0000, st | 8'h42});
		cmd(sfcmd_pkg::OP_WRITE_DISABLE, 0, 0);
		run(RD, 0, 0, 16, {8'h00, st, st});
		$display("test latch done");
		for (int i = 0; i < 8; i++)
		begin
			d = (i < 3) ? 8'($urandom) : dtab[i - 3];
			wp_n = (i < 3) ? 1'b1 : wtab[i - 3];
			cmd(sfcmd_pkg::OP_STATUS_ARM_DEF, 0, 0);
			if (i == 2)
				cmd(WE, 0, 0);
			cmd(sfcmd_pkg::OP_STATUS_WRITE_DEF, {24'h00_0000, d}, 8);
			if (i == 2)
				st[1] = 1'b1;
			else if (wp_n || !st[7])
				st = (st & 8'h73) | (d & 8'h8C);
			run(RD, 0, 0, 16, {8'h00, st, st});
		end
		$display("test status write done");
		for (int i = 0; i < 4; i++)
		begin
			e = i[0] ? {P, M, P} : {M, P, M};
			d = i[1] ? sfcmd_pkg::OP_ID_READ_B : sfcmd_pkg::OP_ID_READ_A;
			run(d, {31'h0, i[0]}, 24, 24, e);
		end
		$display("test id done");
		finish_test();
	end
endmodule
